// ===== hw/cpu_subset_exec.sv
/*
 * Executor for the back half of the 8-bit CPU instruction set. Holds the
 * accumulator, index, stack pointer and status registers, counts each
 * instruction's cycles, runs stack pushes and pulls and reports stores,
 * program counter loads and branch outcomes.
 * Assumes the fetch path hands over the opcode with the memory operand
 * already read, the page-crossing hints, and a stack RAM whose read data
 * is valid one cycle after the read strobe.
 */
//
// Summary of operation
// - rotate left through carry, five forms
// - rotate right through carry, five forms
// - interrupt return pulls status, then PC
// - subroutine return pulls PC, flags kept
// - subtract with borrow updates N V Z C
// - store accumulator, flags untouched
// - store Y, flags untouched
// - copy A to X or Y, set N Z
// - copy X or Y to A, set N Z
// - stack pointer and X copies, set N Z
// - OR memory into accumulator
// - push A or status, post-decrement pointer
// - pull A or status, pre-increment pointer
// - set carry, decimal or interrupt-disable
// - page crossing adds one cycle
// - taken branch adds one, crossing two
`timescale 1ns/10ps
module cpu_subset_exec (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [7:0] opcode,
	input wire logic [7:0] mem_operand,
	input wire logic page_cross,
	input wire logic branch_cross,
	output logic done,
	output logic illegal,
	output logic [1:0] instr_bytes,
	output logic branch_taken,
	output logic store_valid,
	output logic [7:0] store_data,
	output logic stk_re,
	output logic stk_we,
	output logic [7:0] stk_addr,
	output logic [7:0] stk_wdata,
	input wire logic [7:0] stk_rdata,
	output logic pc_load,
	output logic [15:0] pc_value,
	output logic [7:0] acc,
	output logic [7:0] idx_x,
	output logic [7:0] idx_y,
	output logic [7:0] sp,
	output logic [7:0] status
);
	import cpu_subset_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	state_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	dec_s info_reg, info_next;
	logic [7:0] opnd_reg, opnd_next;
	logic [1:0] pull_left_reg, pull_left_next;
	logic rd_pend_reg, rd_pend_next;
	logic [23:0] pull_buf_reg, pull_buf_next;
	logic [7:0] a_reg, a_next;
	logic [7:0] x_reg, x_next;
	logic [7:0] y_reg, y_next;
	logic [7:0] sp_reg, sp_next;
	logic [7:0] p_reg, p_next;
	logic illegal_reg, illegal_next;
	logic [1:0] bytes_reg, bytes_next;
	logic taken_reg, taken_next;
	logic taken_out_reg, taken_out_next;
	logic store_valid_reg, store_valid_next;
	logic [7:0] store_data_reg, store_data_next;
	logic stk_re_reg, stk_re_next;
	logic stk_we_reg, stk_we_next;
	logic [7:0] stk_addr_reg, stk_addr_next;
	logic [7:0] stk_wdata_reg, stk_wdata_next;
	logic pc_load_reg, pc_load_next;
	logic [15:0] pc_value_reg, pc_value_next;

	logic accept;
	logic cond_true;
	logic [3:0] total;
	logic [7:0] src_val;
	logic [7:0] sp_fwd;

	core_if cif ();

	////////////////////////////////////////////////////////////////////////
	// helpers

	// picks a register value by selector; used for issue and commit
	function automatic logic [7:0] pick(reg_sel_e s, logic [7:0] a, logic [7:0] x,
		logic [7:0] y, logic [7:0] sptr, logic [7:0] m, logic [7:0] p);
		logic [7:0] v;
		v = BYTE_ZERO;
		unique case (s)
			R_A: v = a;
			R_X: v = x;
			R_Y: v = y;
			R_SP: v = sptr;
			R_MEM: v = m;
			R_P: v = p;
			default: v = BYTE_ZERO;
		endcase
		return v;
	endfunction

	// branch condition: bits 7:6 pick N V C Z, bit 5 the wanted value
	function automatic logic branch_cond(logic [7:0] op, logic [7:0] p);
		logic f;
		unique case (op[7:6])
			2'h0: f = p[FLAG_N];
			2'h1: f = p[FLAG_V];
			2'h2: f = p[FLAG_C];
			default: f = p[FLAG_Z];
		endcase
		return f == op[5];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules

	assign cif.opcode = opcode;

	opcode_table u_table (
		.cif(cif)
	);

	subset_alu u_alu (
		.cif(cif)
	);

	// the unit always works on the instruction in flight
	assign cif.alu_cls = info_reg.cls;
	assign cif.alu_a = a_reg;
	assign cif.alu_m = pick(info_reg.src, a_reg, x_reg, y_reg, sp_reg, opnd_reg, p_reg);
	assign cif.alu_p_in = p_reg;

	////////////////////////////////////////////////////////////////////////
	// handshake and cycle budget

	assign done = (state_reg == ST_LAST);
	assign instr_ready = (state_reg == ST_IDLE) || done;
	assign accept = instr_valid && instr_ready;
	// issue sees what the finishing instruction commits on the same edge
	assign cond_true = branch_cond(opcode, p_next);
	assign src_val = pick(cif.dec.src, a_next, x_next, y_next, sp_fwd, mem_operand, p_next);

	// base count plus penalties decided at issue time
	always_comb begin
		total = cif.dec.cycles;
		if (cif.dec.penalty && page_cross) begin
			total = total + CYC_ONE;
		end
		if (cif.dec.cls == C_BRANCH && cond_true) begin
			total = total + (branch_cross ? CYC_TWO : CYC_ONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer and stack traffic

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		info_next = info_reg;
		opnd_next = opnd_reg;
		pull_left_next = pull_left_reg;
		rd_pend_next = stk_re_reg;
		pull_buf_next = pull_buf_reg;
		taken_next = taken_reg;
		stk_re_next = 1'b0;
		stk_we_next = 1'b0;
		stk_addr_next = stk_addr_reg;
		stk_wdata_next = stk_wdata_reg;
		bytes_next = bytes_reg;
		// stack read data arrives one cycle after the strobe
		if (rd_pend_reg) begin
			pull_buf_next = {pull_buf_reg[15:0], stk_rdata};
		end
		if (state_reg == ST_RUN) begin
			cnt_next = cnt_reg - CYC_ONE;
			if (cnt_reg == CYC_ONE) begin
				state_next = ST_LAST;
			end
		end else if (state_reg == ST_LAST) begin
			state_next = ST_IDLE;
		end
		// remaining pulls, each one pre-incrementing the pointer
		if (state_reg == ST_RUN && pull_left_reg != PULL_NONE) begin
			stk_re_next = 1'b1;
			stk_addr_next = sp_reg + 8'h01;
			pull_left_next = pull_left_reg - PULL_ONE;
		end
		if (accept) begin
			info_next = cif.dec;
			opnd_next = mem_operand;
			bytes_next = cif.dec.bytes;
			taken_next = (cif.dec.cls == C_BRANCH) && cond_true;
			pull_left_next = PULL_NONE;
			if (total == CYC_TWO) begin
				state_next = ST_LAST;
				cnt_next = CYC_ZERO;
			end else begin
				state_next = ST_RUN;
				cnt_next = total - CYC_TWO;
			end
			unique case (cif.dec.cls)
				C_PUSH: begin
					stk_we_next = 1'b1;
					stk_addr_next = sp_fwd;
					stk_wdata_next = src_val;
				end
				C_PULL, C_RTS, C_RTI: begin
					stk_re_next = 1'b1;
					stk_addr_next = sp_fwd + 8'h01;
					if (cif.dec.cls == C_RTI) begin
						pull_left_next = PULL_RTS;
					end else if (cif.dec.cls == C_RTS) begin
						pull_left_next = PULL_ONE;
					end
				end
				default: stk_we_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= CYC_ZERO;
			info_reg <= mk(C_NOP, R_NONE, R_NONE, 2'h1, 4'h2, 1'b0);
			opnd_reg <= BYTE_ZERO;
			pull_left_reg <= PULL_NONE;
			rd_pend_reg <= 1'b0;
			pull_buf_reg <= 24'h000000;
			taken_reg <= 1'b0;
			stk_re_reg <= 1'b0;
			stk_we_reg <= 1'b0;
			stk_addr_reg <= BYTE_ZERO;
			stk_wdata_reg <= BYTE_ZERO;
			bytes_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			info_reg <= info_next;
			opnd_reg <= opnd_next;
			pull_left_reg <= pull_left_next;
			rd_pend_reg <= rd_pend_next;
			pull_buf_reg <= pull_buf_next;
			taken_reg <= taken_next;
			stk_re_reg <= stk_re_next;
			stk_we_reg <= stk_we_next;
			stk_addr_reg <= stk_addr_next;
			stk_wdata_reg <= stk_wdata_next;
			bytes_reg <= bytes_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// architectural registers and commit

	always_comb begin
		a_next = a_reg;
		x_next = x_reg;
		y_next = y_reg;
		sp_next = sp_reg;
		p_next = p_reg;
		illegal_next = 1'b0;
		taken_out_next = 1'b0;
		store_valid_next = 1'b0;
		store_data_next = store_data_reg;
		pc_load_next = 1'b0;
		pc_value_next = pc_value_reg;
		if (done) begin
			unique case (info_reg.cls)
				C_ORA, C_SBC, C_ROL, C_ROR, C_LSR, C_MOVE: begin
					p_next = cif.alu_p_out;
					unique case (info_reg.dst)
						R_A: a_next = cif.alu_res;
						R_X: x_next = cif.alu_res;
						R_Y: y_next = cif.alu_res;
						R_SP: sp_next = cif.alu_res;
						default: begin
							store_valid_next = 1'b1;
							store_data_next = cif.alu_res;
						end
					endcase
				end
				C_STORE: begin
					store_valid_next = 1'b1;
					store_data_next = cif.alu_m;
				end
				C_PULL: begin
					if (info_reg.dst == R_P) begin
						p_next = pull_buf_reg[7:0];
					end else begin
						a_next = pull_buf_reg[7:0];
					end
				end
				C_RTI: begin
					p_next = pull_buf_reg[23:16];
					pc_load_next = 1'b1;
					pc_value_next = {pull_buf_reg[7:0], pull_buf_reg[15:8]};
				end
				C_RTS: begin
					pc_load_next = 1'b1;
					pc_value_next = {pull_buf_reg[7:0], pull_buf_reg[15:8]};
				end
				C_SEC, C_SED, C_SEI: p_next = cif.alu_p_out;
				C_BRANCH: taken_out_next = taken_reg;
				C_ILLEGAL: illegal_next = 1'b1;
				default: illegal_next = 1'b0;
			endcase
		end
		// pointer after this commit, then moved by a new stack strobe
		sp_fwd = sp_next;
		if (stk_we_next) begin
			sp_next = sp_fwd - 8'h01;
		end
		if (stk_re_next) begin
			sp_next = sp_fwd + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_reg <= A_RESET;
			x_reg <= X_RESET;
			y_reg <= Y_RESET;
			sp_reg <= SP_RESET;
			p_reg <= P_RESET;
			illegal_reg <= 1'b0;
			taken_out_reg <= 1'b0;
			store_valid_reg <= 1'b0;
			store_data_reg <= BYTE_ZERO;
			pc_load_reg <= 1'b0;
			pc_value_reg <= PC_ZERO;
		end else begin
			a_reg <= a_next;
			x_reg <= x_next;
			y_reg <= y_next;
			sp_reg <= sp_next;
			p_reg <= p_next;
			illegal_reg <= illegal_next;
			taken_out_reg <= taken_out_next;
			store_valid_reg <= store_valid_next;
			store_data_reg <= store_data_next;
			pc_load_reg <= pc_load_next;
			pc_value_reg <= pc_value_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign illegal = illegal_reg;
	assign instr_bytes = bytes_reg;
	assign branch_taken = taken_out_reg;
	assign store_valid = store_valid_reg;
	assign store_data = store_data_reg;
	assign stk_re = stk_re_reg;
	assign stk_we = stk_we_reg;
	assign stk_addr = stk_addr_reg;
	assign stk_wdata = stk_wdata_reg;
	assign pc_load = pc_load_reg;
	assign pc_value = pc_value_reg;
	assign acc = a_reg;
	assign idx_x = x_reg;
	assign idx_y = y_reg;
	assign sp = sp_reg;
	assign status = p_reg;

endmodule

// ===== hw/opcode_table.sv
/*
 * Opcode table: maps an opcode onto class, operand source, destination,
 * byte count, base cycle count and page-penalty mark.
 * Assumes the executor adds penalties and branch extras itself.
 */
`timescale 1ns/10ps
module opcode_table (
	core_if.table_end cif
);
	import cpu_subset_pkg::*;

	// combinational table lookup
	always_comb begin
		if (cif.opcode[4:0] == BRANCH_LOW) begin
			cif.dec = mk(C_BRANCH, R_NONE, R_NONE, 2'h2, 4'h2, 1'b0);
		end else begin
			unique case (cif.opcode)
				8'h2A: cif.dec = mk(C_ROL, R_A, R_A, 2'h1, 4'h2, 1'b0);
				8'h26: cif.dec = mk(C_ROL, R_MEM, R_MEM, 2'h2, 4'h5, 1'b0);
				8'h36: cif.dec = mk(C_ROL, R_MEM, R_MEM, 2'h2, 4'h6, 1'b0);
				8'h2E: cif.dec = mk(C_ROL, R_MEM, R_MEM, 2'h3, 4'h6, 1'b0);
				8'h3E: cif.dec = mk(C_ROL, R_MEM, R_MEM, 2'h3, 4'h6, 1'b1);
				8'h6A: cif.dec = mk(C_ROR, R_A, R_A, 2'h1, 4'h2, 1'b0);
				8'h66: cif.dec = mk(C_ROR, R_MEM, R_MEM, 2'h2, 4'h5, 1'b0);
				8'h76: cif.dec = mk(C_ROR, R_MEM, R_MEM, 2'h2, 4'h6, 1'b0);
				8'h6E: cif.dec = mk(C_ROR, R_MEM, R_MEM, 2'h3, 4'h6, 1'b0);
				8'h7E: cif.dec = mk(C_ROR, R_MEM, R_MEM, 2'h3, 4'h6, 1'b1);
				8'h40: cif.dec = mk(C_RTI, R_NONE, R_P, 2'h1, 4'h6, 1'b0);
				8'h60: cif.dec = mk(C_RTS, R_NONE, R_NONE, 2'h1, 4'h6, 1'b0);
				8'hE9: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h2, 4'h2, 1'b0);
				8'hE5: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h2, 4'h3, 1'b0);
				8'hF5: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h2, 4'h4, 1'b0);
				8'hED: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h3, 4'h4, 1'b0);
				8'hFD: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h3, 4'h4, 1'b1);
				8'hF9: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h3, 4'h4, 1'b1);
				8'hE1: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h2, 4'h6, 1'b0);
				8'hF1: cif.dec = mk(C_SBC, R_MEM, R_A, 2'h2, 4'h5, 1'b1);
				8'h85: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h2, 4'h3, 1'b0);
				8'h95: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h2, 4'h4, 1'b0);
				8'h8D: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h3, 4'h4, 1'b0);
				8'h9D: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h3, 4'h5, 1'b0);
				8'h99: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h3, 4'h5, 1'b0);
				8'h81: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h2, 4'h6, 1'b0);
				8'h91: cif.dec = mk(C_STORE, R_A, R_MEM, 2'h2, 4'h6, 1'b0);
				8'h84: cif.dec = mk(C_STORE, R_Y, R_MEM, 2'h2, 4'h3, 1'b0);
				8'h94: cif.dec = mk(C_STORE, R_Y, R_MEM, 2'h2, 4'h4, 1'b0);
				8'h8C: cif.dec = mk(C_STORE, R_Y, R_MEM, 2'h3, 4'h4, 1'b0);
				8'hAA: cif.dec = mk(C_MOVE, R_A, R_X, 2'h1, 4'h2, 1'b0);
				8'hA8: cif.dec = mk(C_MOVE, R_A, R_Y, 2'h1, 4'h2, 1'b0);
				8'h8A: cif.dec = mk(C_MOVE, R_X, R_A, 2'h1, 4'h2, 1'b0);
				8'h98: cif.dec = mk(C_MOVE, R_Y, R_A, 2'h1, 4'h2, 1'b0);
				8'hBA: cif.dec = mk(C_MOVE, R_SP, R_X, 2'h1, 4'h2, 1'b0);
				8'h9A: cif.dec = mk(C_MOVE, R_X, R_SP, 2'h1, 4'h2, 1'b0);
				8'h09: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h2, 4'h2, 1'b0);
				8'h05: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h2, 4'h3, 1'b0);
				8'h15: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h2, 4'h4, 1'b0);
				8'h0D: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h3, 4'h4, 1'b0);
				8'h1D: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h3, 4'h4, 1'b1);
				8'h19: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h3, 4'h4, 1'b1);
				8'h01: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h2, 4'h6, 1'b0);
				8'h11: cif.dec = mk(C_ORA, R_MEM, R_A, 2'h2, 4'h5, 1'b1);
				8'h48: cif.dec = mk(C_PUSH, R_A, R_NONE, 2'h1, 4'h3, 1'b0);
				8'h08: cif.dec = mk(C_PUSH, R_P, R_NONE, 2'h1, 4'h3, 1'b0);
				8'h68: cif.dec = mk(C_PULL, R_NONE, R_A, 2'h1, 4'h4, 1'b0);
				8'h28: cif.dec = mk(C_PULL, R_NONE, R_P, 2'h1, 4'h4, 1'b0);
				8'h38: cif.dec = mk(C_SEC, R_NONE, R_P, 2'h1, 4'h2, 1'b0);
				8'hF8: cif.dec = mk(C_SED, R_NONE, R_P, 2'h1, 4'h2, 1'b0);
				8'h78: cif.dec = mk(C_SEI, R_NONE, R_P, 2'h1, 4'h2, 1'b0);
				8'h4A: cif.dec = mk(C_LSR, R_A, R_A, 2'h1, 4'h2, 1'b0);
				8'h46: cif.dec = mk(C_LSR, R_MEM, R_MEM, 2'h2, 4'h5, 1'b0);
				8'h56: cif.dec = mk(C_LSR, R_MEM, R_MEM, 2'h2, 4'h6, 1'b0);
				8'h4E: cif.dec = mk(C_LSR, R_MEM, R_MEM, 2'h3, 4'h6, 1'b0);
				8'h5E: cif.dec = mk(C_LSR, R_MEM, R_MEM, 2'h3, 4'h6, 1'b1);
				8'hEA: cif.dec = mk(C_NOP, R_NONE, R_NONE, 2'h1, 4'h2, 1'b0);
				8'h86: cif.dec = mk(C_STORE, R_X, R_MEM, 2'h2, 4'h3, 1'b0);
				8'h96: cif.dec = mk(C_STORE, R_X, R_MEM, 2'h2, 4'h4, 1'b0);
				8'h8E: cif.dec = mk(C_STORE, R_X, R_MEM, 2'h3, 4'h4, 1'b0);
				default: cif.dec = mk(C_ILLEGAL, R_NONE, R_NONE, 2'h1, 4'h2, 1'b0);
			endcase
		end
	end

endmodule

// ===== hw/subset_alu.sv
/*
 * Arithmetic and flag unit: OR, subtract with borrow, rotates, shift,
 * plain moves and flag sets. Binary arithmetic only.
 * Assumes the executor routes the result and status to their targets.
 */
`timescale 1ns/10ps
module subset_alu (
	core_if.alu_end cif
);
	import cpu_subset_pkg::*;

	logic [8:0] diff;
	logic [7:0] res;
	logic [7:0] p;
	logic nz_upd;

	// result and flag computation
	always_comb begin
		diff = {1'b0, cif.alu_a} - {1'b0, cif.alu_m} - {8'h00, ~cif.alu_p_in[FLAG_C]};
		res = cif.alu_m;
		p = cif.alu_p_in;
		nz_upd = 1'b0;
		unique case (cif.alu_cls)
			C_ORA: begin
				res = cif.alu_a | cif.alu_m;
				nz_upd = 1'b1;
			end
			C_SBC: begin
				res = diff[7:0];
				p[FLAG_C] = ~diff[8];
				p[FLAG_V] = (cif.alu_a[7] ^ cif.alu_m[7]) & (cif.alu_a[7] ^ diff[7]);
				nz_upd = 1'b1;
			end
			C_ROL: begin
				res = {cif.alu_m[6:0], cif.alu_p_in[FLAG_C]};
				p[FLAG_C] = cif.alu_m[7];
				nz_upd = 1'b1;
			end
			C_ROR: begin
				res = {cif.alu_p_in[FLAG_C], cif.alu_m[7:1]};
				p[FLAG_C] = cif.alu_m[0];
				nz_upd = 1'b1;
			end
			C_LSR: begin
				res = {1'b0, cif.alu_m[7:1]};
				p[FLAG_C] = cif.alu_m[0];
				nz_upd = 1'b1;
			end
			C_MOVE: nz_upd = 1'b1;
			C_SEC: p[FLAG_C] = 1'b1;
			C_SED: p[FLAG_D] = 1'b1;
			C_SEI: p[FLAG_I] = 1'b1;
			default: nz_upd = 1'b0;
		endcase
		if (nz_upd) begin
			p[FLAG_N] = res[7];
			p[FLAG_Z] = (res == BYTE_ZERO);
		end
		cif.alu_res = res;
		cif.alu_p_out = p;
	end

endmodule

// ===== pkg/core_if.sv
/*
 * Carrier between the executor and its opcode table and arithmetic unit.
 * Assumes all three sit on the same core clock; everything here is
 * combinational.
 */
`timescale 1ns/10ps
interface core_if;
	import cpu_subset_pkg::*;
	logic [7:0] opcode;
	dec_s dec;
	cls_e alu_cls;
	logic [7:0] alu_a;
	logic [7:0] alu_m;
	logic [7:0] alu_p_in;
	logic [7:0] alu_res;
	logic [7:0] alu_p_out;
	modport table_end (input opcode, output dec);
	modport alu_end (input alu_cls, alu_a, alu_m, alu_p_in, output alu_res, alu_p_out);
	modport core_end (output opcode, alu_cls, alu_a, alu_m, alu_p_in,
		input dec, alu_res, alu_p_out);
endinterface

// ===== pkg/cpu_subset_pkg.sv
/*
 * Shared definitions for the instruction subset decoder and executor:
 * status flag positions, reset values, instruction classes, register
 * selectors, the decoded instruction record and the state encoding.
 * Assumes a single core clock domain and an 8-bit datapath.
 */
package cpu_subset_pkg;

	// status register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_I = 2;
	localparam int FLAG_D = 3;
	localparam int FLAG_V = 6;
	localparam int FLAG_N = 7;

	// reset values of the programmer-visible registers
	localparam logic [7:0] A_RESET = 8'h00;
	localparam logic [7:0] X_RESET = 8'h00;
	localparam logic [7:0] Y_RESET = 8'h00;
	localparam logic [7:0] SP_RESET = 8'hFF;
	localparam logic [7:0] P_RESET = 8'h04;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] PC_ZERO = 16'h0000;

	// cycle counting constants
	localparam logic [3:0] CYC_ZERO = 4'h0;
	localparam logic [3:0] CYC_ONE = 4'h1;
	localparam logic [3:0] CYC_TWO = 4'h2;

	// stack pull counts
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_ONE = 2'h1;
	localparam logic [1:0] PULL_RTS = 2'h2;
	localparam logic [1:0] PULL_RTI = 2'h3;

	// conditional branch opcodes share this low pattern
	localparam logic [4:0] BRANCH_LOW = 5'h10;

	typedef enum logic [4:0] {
		C_ILLEGAL, C_NOP, C_ORA, C_SBC, C_ROL, C_ROR, C_LSR, C_MOVE, C_STORE,
		C_PUSH, C_PULL, C_RTI, C_RTS, C_SEC, C_SED, C_SEI, C_BRANCH
	} cls_e;

	typedef enum logic [2:0] {
		R_A, R_X, R_Y, R_SP, R_MEM, R_P, R_NONE
	} reg_sel_e;

	typedef struct packed {
		cls_e cls;
		reg_sel_e src;
		reg_sel_e dst;
		logic [1:0] bytes;
		logic [3:0] cycles;
		logic penalty;
	} dec_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_LAST = 2'b11
	} state_e;

	// builds one decoded record
	function automatic dec_s mk(cls_e c, reg_sel_e s, reg_sel_e d, logic [1:0] b,
		logic [3:0] n, logic pen);
		dec_s r;
		r.cls = c;
		r.src = s;
		r.dst = d;
		r.bytes = b;
		r.cycles = n;
		r.penalty = pen;
		return r;
	endfunction

endpackage

// ===== testbench/cpu_subset_exec_tb.sv
/* self-checking bench: reference model with a stack image, random operands.
   assumes the executor handshake and one-cycle stack read latency. */
`timescale 1ns/10ps
module cpu_subset_exec_tb;
	logic clk, arst_n, instr_valid, page_cross, branch_cross, instr_ready, done, illegal;
	logic branch_taken, store_valid, stk_re, stk_we, pc_load;
	logic [7:0] opcode, mem_operand, stk_rdata, store_data, stk_addr, stk_wdata;
	logic [7:0] acc, idx_x, idx_y, sp, status, ma, mx, my, ms, mp;
	logic [7:0] ram [256];
	logic [7:0] mram [256];
	logic [1:0] instr_bytes;
	logic [15:0] pc_value;
	logic [31:0] seed = 32'hC372;
	int fails = 0;
	int samples_checked = 0;
	// opcode, then bytes in 6:5, penalty mark in 4 and base cycles in 3:0
	logic [15:0] tbl [32] = '{16'h0942, 16'h0543, 16'h0146, 16'h1155, 16'hE942, 16'hF155,
		16'h2A22, 16'h6A22, 16'h2645, 16'h3E76, 16'h4A22, 16'hAA22, 16'hA822, 16'h8A22,
		16'h9822, 16'hBA22, 16'h9A22, 16'h4823, 16'h0823, 16'h6824, 16'h2824, 16'h3822,
		16'hF822, 16'h7822, 16'h8543, 16'h8443, 16'hEA22, 16'h6026, 16'h4026, 16'hF042,
		16'hD042, 16'h0222};
	cpu_subset_exec uut (.*);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic void nz(logic [7:0] v);
		mp[7] = v[7];
		mp[1] = (v == 8'h00);
	endfunction
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one instruction through model and design
	task automatic run(input logic [7:0] op, input logic [7:0] inf);
		logic [7:0] m, r, sd;
		logic pc, bc, sv, tk, il, pl;
		logic [15:0] pv;
		int n, e, t;
		m = 8'(rnd());
		pc = 1'(rnd());
		bc = 1'(rnd());
		e = inf[3:0] + (inf[4] & pc);
		{sv, tk, il, sd, pv} = '0;
		pl = (op == 8'h60 || op == 8'h40);
		case (op)
			8'h09, 8'h05, 8'h01, 8'h11: begin ma = ma | m; nz(ma); end
			8'hE9, 8'hF1: begin
				t = int'(ma) - int'(m) - (mp[0] ? 0 : 1);
				r = t[7:0];
				mp[0] = (t >= 0);
				mp[6] = (ma[7] ^ m[7]) & (ma[7] ^ r[7]);
				ma = r;
				nz(r);
			end
			8'h2A: begin r = {ma[6:0], mp[0]}; mp[0] = ma[7]; ma = r; nz(r); end
			8'h6A: begin r = {mp[0], ma[7:1]}; mp[0] = ma[0]; ma = r; nz(r); end
			8'h26, 8'h3E: begin sd = {m[6:0], mp[0]}; mp[0] = m[7]; nz(sd); sv = 1; end
			8'h4A: begin mp[0] = ma[0]; ma = ma >> 1; nz(ma); end
			8'hAA: begin mx = ma; nz(mx); end
			8'hA8: begin my = ma; nz(my); end
			8'h8A: begin ma = mx; nz(ma); end
			8'h98: begin ma = my; nz(ma); end
			8'hBA: begin mx = ms; nz(mx); end
			8'h9A: begin ms = mx; nz(mx); end
			8'h48: begin mram[ms] = ma; ms--; end
			8'h08: begin mram[ms] = mp; ms--; end
			8'h68: begin ms++; ma = mram[ms]; end
			8'h28: begin ms++; mp = mram[ms]; end
			8'h38: mp[0] = 1;
			8'hF8: mp[3] = 1;
			8'h78: mp[2] = 1;
			8'h85: begin sd = ma; sv = 1; end
			8'h84: begin sd = my; sv = 1; end
			8'h60: begin pv = {mram[ms + 8'h02], mram[ms + 8'h01]}; ms += 2; end
			8'h40: begin
				mp = mram[ms + 8'h01];
				pv = {mram[ms + 8'h03], mram[ms + 8'h02]};
				ms += 3;
			end
			8'hF0, 8'hD0: begin tk = mp[1] ^ (op == 8'hD0); e += tk + (tk & bc); end
			8'h02: il = 1;
			default: ;
		endcase
		instr_valid = 1;
		opcode = op;
		mem_operand = m;
		page_cross = pc;
		branch_cross = bc;
		@(posedge clk);
		#1;
		instr_valid = 0;
		n = 1;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(n + 1, e);
		@(posedge clk);
		#1;
		check({acc, idx_x}, {ma, mx});
		check({idx_y, sp}, {my, ms});
		check(status, mp);
		check({illegal, store_valid, pc_load, branch_taken}, {il, sv, pl, tk});
		check(instr_bytes, inf[6:5]);
		if (sv) check(store_data, sd);
		if (pl) check(pc_value, pv);
	endtask
	// clock
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// stack memory answering one cycle after the read strobe
	always @(posedge clk) begin
		if (stk_we) ram[stk_addr] <= stk_wdata;
		stk_rdata <= stk_re ? ram[stk_addr] : ~stk_rdata;
	end
	// watchdog
	initial begin
		#100000;
		fails++;
		stop_test;
	end
	// main sequence
	initial begin
		{arst_n, instr_valid, page_cross, branch_cross, opcode, mem_operand, stk_rdata} = '0;
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'(rnd());
			mram[i] = ram[i];
		end
		{ma, mx, my, ms, mp} = {24'h0, 8'hFF, 8'h04};
		repeat (8) @(posedge clk);
		#1;
		arst_n = 1;
		check({acc, sp, status}, {ma, ms, mp});
		for (int k = 0; k < 4; k++) begin
			foreach (tbl[i]) run(tbl[i][15:8], tbl[i][7:0]);
			// mid-run reset: registers return to their reset values
			if (k == 1) begin
				arst_n = 0;
				@(posedge clk);
				#1;
				arst_n = 1;
				{ma, mx, my, ms, mp} = {24'h0, 8'hFF, 8'h04};
				check({acc, sp, status}, {ma, ms, mp});
			end
		end
		stop_test;
	end
endmodule

// ===== testbench/cpu_subset_props.sv
/* checker: cycle counts, stack strobes and flag effects of the executor.
   assumes binding to cpu_subset_exec on its single core clock. */
`timescale 1ns/10ps
module cpu_subset_props (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [7:0] opcode,
	input wire logic page_cross,
	input wire logic done,
	input wire logic illegal,
	input wire logic stk_re,
	input wire logic stk_we,
	input wire logic pc_load,
	input wire logic store_valid,
	input wire logic [7:0] acc,
	input wire logic [7:0] idx_x,
	input wire logic [7:0] status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// an instruction is taken on this edge
	wire take = instr_valid && instr_ready;
	////////////////////////////////////////////////////////////////
	AST_PUSH: assert property (take && opcode == 8'h48 |=> stk_we ##1 done)
		else $error("push timing wrong");
	AST_PULL: assert property (take && opcode == 8'h68 |=> stk_re ##2 done)
		else $error("pull timing wrong");
	AST_SUB_RET: assert property (take && opcode == 8'h60 |=> stk_re [*2] ##3 done ##1 pc_load)
		else $error("subroutine return timing wrong");
	AST_SUB_FLAGS: assert property (take && opcode == 8'h60 |-> ##2 $stable(status) [*5])
		else $error("subroutine return touched flags");
	AST_INT_RET: assert property (take && opcode == 8'h40 |=> stk_re [*3] ##2 done ##1 pc_load)
		else $error("interrupt return timing wrong");
	AST_PENALTY: assert property (take && opcode == 8'h3E && page_cross |=> !instr_ready [*5] ##1 done)
		else $error("page penalty cycle missing");
	AST_STORE: assert property (take && opcode == 8'h85 |-> ##3 store_valid && status == $past(status, 2))
		else $error("store wrong");
	AST_SET_C: assert property (take && opcode == 8'h38 |-> ##2 status == ($past(status) | 8'h01))
		else $error("carry set wrong");
	AST_COPY_X: assert property (take && opcode == 8'hAA |-> ##2 idx_x == $past(acc))
		else $error("copy to x wrong");
	// main scenarios
	cover property (take && opcode == 8'h40);
	cover property (take && opcode == 8'h3E && page_cross);
	cover property (illegal);
endmodule
bind cpu_subset_exec cpu_subset_props u_props (.clk, .arst_n, .instr_valid, .instr_ready,
	.opcode, .page_cross, .done, .illegal, .stk_re, .stk_we, .pc_load, .store_valid, .acc,
	.idx_x, .status);
